// [itr_pkg.sv]
// Shared constants and types for the issue timing and return predictor
//
// Operation
// - A four-entry return-address stack predicts procedure return targets.
// - Load multiple writing program counter without status restore is a return.
// - Base register must be ready at the very-early operand stage.
// - Correct return prediction costs the normal issue and memory cycles.
// - Unconditional load multiple with wrong return prediction adds eight cycles.
// - Conditional load multiple with mispredicted condition adds seven cycles.
// - Right condition but wrong return prediction adds eight cycles.
// - Push and pop time like store and load multiple with writeback.
// - Consumer of seventh register of aligned load multiple waits: six cycles.
// - Aligned seven-register store then overwrite completes in five cycles.
// - Consumer of ninth register of aligned pop waits: seven cycles.
// - Exception-return and state-save use one memory cycle aligned, two not.
// - Return from exception takes ten cycles aligned, eleven unaligned.
// - Save return state takes one cycle aligned, two unaligned.
// - Exclusives issue in one cycle, latency two; clear-exclusive one cycle.
// - Swap word and byte take two cycles, two memory, latency three.
// - Barriers stall as long as the memory system requires.
// - Coprocessor transfers take six cycles, latency six; four on fail.
// - Call, breakpoint, undefined and prefetch abort are taken at writeback.
// - Taking those exceptions costs nine cycles.
// - Failed call or undefined takes one cycle; a small subset two.
package itr_pkg;
  typedef enum logic [3:0] {
    ITR_OP_NONE,
    ITR_OP_LDM,
    ITR_OP_STM,
    ITR_OP_RFE,
    ITR_OP_SRS,
    ITR_OP_EXCL,
    ITR_OP_CLEAR_EXCLUSIVE_INSN,
    ITR_OP_SWAP,
    ITR_OP_BARRIER,
    ITR_OP_COPROC,
    ITR_OP_EXCEPT
  } itr_op_t;

  localparam int unsigned ITR_STACK_DEPTH = 4;
  localparam int unsigned ITR_PTR_W = 2;
  localparam int unsigned ITR_CNT_W = 5;
  localparam logic [4:0] ITR_RET_MISS_PEN = 5'h08;
  localparam logic [4:0] ITR_COND_MISS_PEN = 5'h07;
  localparam logic [4:0] ITR_RFE_ALIGNED = 5'h0a;
  localparam logic [4:0] ITR_RFE_UNALIGNED = 5'h0b;
  localparam logic [4:0] ITR_SRS_ALIGNED = 5'h01;
  localparam logic [4:0] ITR_SRS_UNALIGNED = 5'h02;
  localparam logic [4:0] ITR_EXCL_CYC = 5'h01;
  localparam logic [4:0] ITR_EXCL_LAT = 5'h02;
  localparam logic [4:0] ITR_SWAP_CYC = 5'h02;
  localparam logic [4:0] ITR_SWAP_LAT = 5'h03;
  localparam logic [4:0] ITR_CP_PASS_CYC = 5'h06;
  localparam logic [4:0] ITR_CP_FAIL_CYC = 5'h04;
  localparam logic [4:0] ITR_EXC_CYC = 5'h09;
  localparam logic [4:0] ITR_EXC_FAIL_CYC = 5'h01;
  localparam logic [4:0] ITR_EXC_FAIL_SLOW_CYC = 5'h02;
  localparam logic [4:0] ITR_MEM_ONE = 5'h01;
  localparam logic [4:0] ITR_MEM_TWO = 5'h02;
  localparam logic [4:0] ITR_LDM_FIRST_LAT = 5'h02;
  localparam logic [31:0] ITR_RESET_ADDR = 32'h0000_0000;
endpackage

// [itr_return_stack.sv]
// Four-entry return-address stack used by the issue controller
`timescale 1ns/1ps
`default_nettype none
module itr_return_stack
  import itr_pkg::*;
(
  input wire logic i_clock,          // Processor clock
  input wire logic i_rstn,           // Synchronous reset, active low
  input wire logic i_push,           // Call seen: push link address
  input wire logic [31:0] i_push_addr, // Return address to store
  input wire logic i_pop,            // Predicted return consumed
  output logic o_valid,              // Top entry holds a prediction
  output logic [31:0] o_top          // Predicted return target
);
  typedef struct packed {
    logic [ITR_STACK_DEPTH-1:0][31:0] addr;
    logic [ITR_STACK_DEPTH-1:0] vld;
    logic [ITR_PTR_W-1:0] ptr;
  } itr_rs_state_t;

  itr_rs_state_t st_r;
  itr_rs_state_t st_nxt;
  logic [ITR_PTR_W-1:0] top_idx;

  assign top_idx = st_r.ptr - 2'h1;
  assign o_valid = st_r.vld[top_idx];
  assign o_top = st_r.addr[top_idx];

  always_comb
  begin
    st_nxt = st_r;
    if (i_pop)
    begin
      st_nxt.vld[top_idx] = 1'b0;
      st_nxt.ptr = top_idx;
    end
    else if (i_push)
    begin
      // Overflow silently overwrites the oldest entry
      st_nxt.addr[st_r.ptr] = i_push_addr;
      st_nxt.vld[st_r.ptr] = 1'b1;
      st_nxt.ptr = st_r.ptr + 2'h1;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      st_r.addr <= '0;
      st_r.vld <= '0;
      st_r.ptr <= '0;
    end
    else
      st_r <= st_nxt;
  end

  chk_reset_empty: assert property (@(posedge i_clock) !i_rstn |=> !o_valid)
    else $error("return stack not empty after reset");
endmodule
`default_nettype wire

// [itr_issue_ctrl.sv]
// Issue timing, interlock and return prediction control for one pipeline
`timescale 1ns/1ps
`default_nettype none
module itr_issue_ctrl
  import itr_pkg::*;
(
  input wire logic i_clock,                // Processor clock, 100 MHz
  input wire logic i_rstn,                 // Synchronous reset, active low
  input wire logic i_valid,                // Instruction offered at issue
  input wire itr_pkg::itr_op_t i_op,       // Instruction class
  input wire logic [4:0] i_base_cycles,    // Normal issue count for multiples
  input wire logic [4:0] i_mem_cycles,     // Normal memory count for multiples
  input wire logic [4:0] i_last_lat,       // Latency of last loaded register
  input wire logic i_writes_pc,            // Load multiple includes PC
  input wire logic i_restores_status,      // Copies saved into current status
  input wire logic i_conditional,          // Instruction has a condition
  input wire logic i_cond_pass,            // Condition outcome
  input wire logic i_cond_mispredict,      // Condition outcome was mispredicted
  input wire logic i_aligned,              // First address doubleword aligned
  input wire logic i_slow_undef,           // Undefined encoding of the slow set
  input wire logic [31:0] i_load_target,   // Target actually loaded into PC
  input wire logic i_call,                 // Branch-and-link seen
  input wire logic [31:0] i_call_ret,      // Its return address
  input wire logic i_base_ready,           // Base register ready, very early
  input wire logic i_consumer_valid,       // Next instruction waiting
  input wire logic [3:0] i_consumer_src,   // Register it reads
  input wire logic [3:0] i_load_last_reg,  // Last register of the load multiple
  input wire logic i_mem_busy,             // Memory system not yet drained
  input wire logic i_cp_done,              // Coprocessor finished
  output logic o_ready,                    // Issue slot free
  output logic o_stall,                    // Later instructions held
  output logic o_mispredict,               // Return or condition mispredicted
  output logic [31:0] o_pred_target,       // Predicted return target
  output logic o_exc_take,                 // Exception taken at writeback
  output logic [4:0] o_issue_cycles,       // Cycles spent by the last instruction
  output logic [4:0] o_mem_cycles,         // Memory cycles of last instruction
  output logic [4:0] o_result_lat          // Result latency of last instruction
);
  typedef enum logic [1:0] {
    ITR_IDLE,
    ITR_COUNT,
    ITR_WAIT_MEM,
    ITR_WAIT_CP
  } itr_state_t;

  typedef struct packed {
    itr_state_t st;
    logic [4:0] remain;
    logic [4:0] spent;
    logic [4:0] issue;
    logic [4:0] mem;
    logic [4:0] lat;
    logic mispred;
    logic [31:0] target;
    logic exc;
    logic exc_pend;
    logic [4:0] ilk;
    logic [3:0] ilk_reg;
  } itr_ctl_t;

  itr_ctl_t s_r;
  itr_ctl_t s_nxt;
  logic rs_valid;
  logic [31:0] rs_top;
  logic is_return;
  logic ret_hit;
  logic accept;
  logic ilk_block;

  function automatic logic [4:0] sat_dec(input logic [4:0] v);
    sat_dec = (v == 5'h00) ? 5'h00 : v - 5'h01;
  endfunction

  assign is_return = (i_op == ITR_OP_LDM) && i_writes_pc && !i_restores_status;
  assign ret_hit = rs_valid && (rs_top == i_load_target);
  assign ilk_block = i_consumer_valid && (s_r.ilk > 5'h01)
    && (i_consumer_src == s_r.ilk_reg);
  assign accept = i_valid && (s_r.st == ITR_IDLE) && i_base_ready && !ilk_block;
  assign o_ready = (s_r.st == ITR_IDLE) && i_base_ready && !ilk_block;
  assign o_stall = (s_r.st != ITR_IDLE) || ilk_block;
  assign o_mispredict = s_r.mispred;
  assign o_pred_target = s_r.target;
  assign o_exc_take = s_r.exc;
  assign o_issue_cycles = s_r.issue;
  assign o_mem_cycles = s_r.mem;
  assign o_result_lat = s_r.lat;

  itr_return_stack u_rs (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_push(i_call),
    .i_push_addr(i_call_ret),
    .i_pop(accept && is_return),
    .o_valid(rs_valid),
    .o_top(rs_top)
  );

  always_comb
  begin
    logic [4:0] cyc;
    cyc = 5'h00;
    s_nxt = s_r;
    s_nxt.mispred = 1'b0;
    s_nxt.exc = 1'b0;
    s_nxt.ilk = sat_dec(s_r.ilk);
    case (s_r.st)
      ITR_IDLE:
      begin
        s_nxt.spent = 5'h00;
        if (accept)
        begin
          s_nxt.mem = 5'h00;
          s_nxt.lat = 5'h00;
          s_nxt.target = rs_top;
          s_nxt.exc_pend = 1'b0;
          case (i_op)
            ITR_OP_LDM, ITR_OP_STM:
            begin
              // push and pop share multiples timing
              cyc = i_base_cycles;
              s_nxt.mem = i_mem_cycles;
              if (i_op == ITR_OP_LDM)
              begin
                s_nxt.lat = i_last_lat;
                s_nxt.ilk = i_last_lat;
                s_nxt.ilk_reg = i_load_last_reg;
              end
              if (is_return)
              begin
                if (i_conditional && i_cond_mispredict)
                begin
                  cyc = i_base_cycles + ITR_COND_MISS_PEN;
                  s_nxt.mispred = 1'b1;
                end
                else if (!ret_hit)
                begin
                  cyc = i_base_cycles + ITR_RET_MISS_PEN;
                  s_nxt.mispred = 1'b1;
                end
              end
            end
            ITR_OP_RFE:
            begin
              cyc = i_aligned ? ITR_RFE_ALIGNED : ITR_RFE_UNALIGNED;
              s_nxt.mem = i_aligned ? ITR_MEM_ONE : ITR_MEM_TWO;
            end
            ITR_OP_SRS:
            begin
              cyc = i_aligned ? ITR_SRS_ALIGNED : ITR_SRS_UNALIGNED;
              s_nxt.mem = i_aligned ? ITR_MEM_ONE : ITR_MEM_TWO;
            end
            ITR_OP_EXCL:
            begin
              cyc = ITR_EXCL_CYC;
              s_nxt.mem = ITR_MEM_ONE;
              s_nxt.lat = ITR_EXCL_LAT;
            end
            ITR_OP_CLEAR_EXCLUSIVE_INSN:
              cyc = ITR_EXCL_CYC;
            ITR_OP_SWAP:
            begin
              cyc = ITR_SWAP_CYC;
              s_nxt.mem = ITR_MEM_TWO;
              s_nxt.lat = ITR_SWAP_LAT;
            end
            ITR_OP_COPROC:
            begin
              cyc = (i_conditional && !i_cond_pass) ? ITR_CP_FAIL_CYC
                : ITR_CP_PASS_CYC;
              s_nxt.lat = cyc;
            end
            ITR_OP_EXCEPT:
            begin
              if (i_conditional && !i_cond_pass)
                cyc = i_slow_undef ? ITR_EXC_FAIL_SLOW_CYC : ITR_EXC_FAIL_CYC;
              else
              begin
                cyc = ITR_EXC_CYC;
                s_nxt.exc_pend = 1'b1;
              end
            end
            default:
              cyc = 5'h01;
          endcase
          s_nxt.spent = 5'h01;
          if (i_op == ITR_OP_BARRIER)
            s_nxt.st = ITR_WAIT_MEM;
          else if (cyc > 5'h01)
          begin
            s_nxt.remain = cyc - 5'h01;
            s_nxt.st = ITR_COUNT;
          end
          else
            s_nxt.issue = 5'h01;
        end
      end
      ITR_COUNT:
      begin
        s_nxt.spent = s_r.spent + 5'h01;
        s_nxt.remain = s_r.remain - 5'h01;
        if (s_r.remain == 5'h01)
        begin
          s_nxt.issue = s_r.spent + 5'h01;
          s_nxt.exc = s_r.exc_pend;
          s_nxt.exc_pend = 1'b0;
          s_nxt.st = ITR_IDLE;
        end
      end
      ITR_WAIT_MEM:
      begin
        s_nxt.spent = s_r.spent + 5'h01;
        if (!i_mem_busy)
        begin
          s_nxt.issue = s_r.spent + 5'h01;
          s_nxt.st = ITR_IDLE;
        end
      end
      ITR_WAIT_CP:
      begin
        s_nxt.spent = s_r.spent + 5'h01;
        if (i_cp_done)
          s_nxt.st = ITR_IDLE;
      end
      default:
        s_nxt.st = ITR_IDLE;
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      s_r.st <= ITR_IDLE;
      s_r.remain <= 5'h00;
      s_r.spent <= 5'h00;
      s_r.issue <= 5'h00;
      s_r.mem <= 5'h00;
      s_r.lat <= 5'h00;
      s_r.mispred <= 1'b0;
      s_r.target <= ITR_RESET_ADDR;
      s_r.exc <= 1'b0;
      s_r.exc_pend <= 1'b0;
      s_r.ilk <= 5'h00;
      s_r.ilk_reg <= 4'h0;
    end
    else
      s_r <= s_nxt;
  end

  sequence exc_issue_s;
    accept && (i_op == ITR_OP_EXCEPT) && !(i_conditional && !i_cond_pass);
  endsequence

  chk_exc_nine_cycles: assert property (@(posedge i_clock) disable iff (!i_rstn)
    exc_issue_s |-> ##9 (o_exc_take && o_issue_cycles == 5'h09))
    else $error("exception not taken after nine cycles");

  chk_rfe_aligned: assert property (@(posedge i_clock) disable iff (!i_rstn)
    accept && i_op == ITR_OP_RFE && i_aligned |-> ##10 (o_issue_cycles == 5'h0a
    && o_mem_cycles == 5'h01))
    else $error("aligned exception return not ten cycles");

  chk_rfe_unaligned: assert property (@(posedge i_clock) disable iff (!i_rstn)
    accept && i_op == ITR_OP_RFE && !i_aligned |-> ##11
    (o_issue_cycles == 5'h0b && o_mem_cycles == 5'h02))
    else $error("unaligned exception return not eleven cycles");

  chk_srs_timing: assert property (@(posedge i_clock) disable iff (!i_rstn)
    accept && i_op == ITR_OP_SRS && !i_aligned |-> ##1 o_stall ##1
    (!o_stall && o_issue_cycles == 5'h02))
    else $error("unaligned state save not two cycles");

  chk_swap_timing: assert property (@(posedge i_clock) disable iff (!i_rstn)
    accept && i_op == ITR_OP_SWAP |-> ##2 (o_result_lat == 5'h03
    && o_mem_cycles == 5'h02 && o_issue_cycles == 5'h02))
    else $error("swap timing wrong");

  chk_excl_timing: assert property (@(posedge i_clock) disable iff (!i_rstn)
    accept && i_op == ITR_OP_EXCL |=> (!o_stall || ilk_block)
    && o_result_lat == 5'h02)
    else $error("exclusive not single cycle");

  chk_cp_fail: assert property (@(posedge i_clock) disable iff (!i_rstn)
    accept && i_op == ITR_OP_COPROC && i_conditional && !i_cond_pass
    |-> ##4 o_issue_cycles == 5'h04)
    else $error("failed coprocessor transfer not four cycles");

  chk_ret_miss: assert property (@(posedge i_clock) disable iff (!i_rstn)
    accept && is_return && !ret_hit && !(i_conditional && i_cond_mispredict)
    |=> o_mispredict)
    else $error("return mispredict not flagged");

  chk_barrier_hold: assert property (@(posedge i_clock) disable iff (!i_rstn)
    s_r.st == ITR_WAIT_MEM && i_mem_busy |=> o_stall)
    else $error("barrier released while memory busy");

  chk_ilk_hold: assert property (@(posedge i_clock) disable iff (!i_rstn)
    ilk_block |-> !accept)
    else $error("consumer issued under interlock");
endmodule
`default_nettype wire

// [itr_mem_model.sv]
// Memory system and coprocessor stand-in facing the issue controller
`timescale 1ns/1ps
`default_nettype none
module itr_mem_model
(
  input wire logic i_clock,           // Processor clock
  input wire logic i_rstn,            // Synchronous reset, active low
  input wire logic i_drain,           // Start a drain of i_drain_len cycles
  input wire logic [4:0] i_drain_len, // Cycles the memory stays busy
  input wire logic i_cp_req,          // Coprocessor operation offered
  output logic o_mem_busy,            // Outstanding memory traffic
  output logic o_cp_done              // Coprocessor finished
);
  logic [4:0] busy_r;
  logic done_r;
  // Busy is a level, so a barrier sees the drain end on a clean edge
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      busy_r <= 5'h00;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= i_cp_req;
      if (i_drain)
        busy_r <= i_drain_len;
      else if (busy_r != 5'h00)
        busy_r <= busy_r - 5'h01;
    end
  end
  assign o_mem_busy = (busy_r != 5'h00);
  assign o_cp_done = done_r;
endmodule
`default_nettype wire

// [issue_timing_return_predict_tb_top.sv]
// Self-checking bench for the issue timing and return predictor
`timescale 1ns/1ps
`default_nettype none
module issue_timing_return_predict_tb_top;
  import itr_pkg::*;
  logic i_clock, i_rstn, i_valid, i_writes_pc, i_restores_status;
  logic i_conditional, i_cond_pass, i_cond_mispredict, i_aligned;
  logic i_slow_undef, i_call, i_base_ready, i_consumer_valid;
  logic i_mem_busy, i_cp_done, drain, cp_req;
  itr_op_t i_op;
  logic [4:0] i_base_cycles, i_mem_cycles, i_last_lat, drain_len;
  logic [31:0] i_load_target, i_call_ret;
  logic [3:0] i_consumer_src, i_load_last_reg;
  logic o_ready, o_stall, o_mispredict, o_exc_take;
  logic [31:0] o_pred_target;
  logic [4:0] o_issue_cycles, o_mem_cycles, o_result_lat;
  int n_mismatch, checks_done, cyc, c3, c9;

  itr_issue_ctrl i_dut (.i_clock(i_clock), .i_rstn(i_rstn),
    .i_valid(i_valid), .i_op(i_op), .i_base_cycles(i_base_cycles),
    .i_mem_cycles(i_mem_cycles), .i_last_lat(i_last_lat),
    .i_writes_pc(i_writes_pc), .i_restores_status(i_restores_status),
    .i_conditional(i_conditional), .i_cond_pass(i_cond_pass),
    .i_cond_mispredict(i_cond_mispredict), .i_aligned(i_aligned),
    .i_slow_undef(i_slow_undef), .i_load_target(i_load_target),
    .i_call(i_call), .i_call_ret(i_call_ret), .i_base_ready(i_base_ready),
    .i_consumer_valid(i_consumer_valid), .i_consumer_src(i_consumer_src),
    .i_load_last_reg(i_load_last_reg), .i_mem_busy(i_mem_busy),
    .i_cp_done(i_cp_done), .o_ready(o_ready), .o_stall(o_stall),
    .o_mispredict(o_mispredict), .o_pred_target(o_pred_target),
    .o_exc_take(o_exc_take), .o_issue_cycles(o_issue_cycles),
    .o_mem_cycles(o_mem_cycles), .o_result_lat(o_result_lat));

  itr_mem_model i_mem (.i_clock(i_clock), .i_rstn(i_rstn), .i_drain(drain),
    .i_drain_len(drain_len), .i_cp_req(cp_req), .o_mem_busy(i_mem_busy),
    .o_cp_done(i_cp_done));

  assign cp_req = i_valid && (i_op == ITR_OP_COPROC);

  initial
  begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // A hung handshake must still reach the closing report
  always @(posedge i_clock)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // Valid is left to the callers so that it never toggles twice in one step
  task automatic clr();
    i_op = ITR_OP_NONE;
    i_base_cycles = 5'h01;
    i_mem_cycles = 5'h01;
    i_last_lat = 5'h02;
    i_writes_pc = 1'b0;
    i_restores_status = 1'b0;
    i_conditional = 1'b0;
    i_cond_pass = 1'b1;
    i_cond_mispredict = 1'b0;
    i_aligned = 1'b1;
    i_slow_undef = 1'b0;
    i_load_target = 32'h0000_0000;
    i_base_ready = 1'b1;
    i_consumer_valid = 1'b0;
    i_consumer_src = 4'h0;
    i_load_last_reg = 4'h0;
  endtask

  // Offer one instruction, measure its stall and check the results
  task automatic go(input itr_op_t op, input int ec, em, el, emis, eexc,
                    output int c);
    int g;
    int exc_at;
    logic mis;
    i_op = op;
    i_valid = 1'b1;
    g = 0;
    #1;
    while (!o_ready && g < 50)
    begin
      @(negedge i_clock);
      #1;
      g++;
    end
    @(negedge i_clock);
    i_valid = 1'b0;
    mis = o_mispredict;
    exc_at = o_exc_take ? 1 : 0;
    c = 1;
    while (o_stall && c < 60)
    begin
      @(negedge i_clock);
      c++;
      if (o_exc_take)
        exc_at = c;
    end
    chk("cycles against stall", c, o_issue_cycles);
    if (ec >= 0) chk("issue cycles", ec, o_issue_cycles);
    if (em >= 0) chk("memory cycles", em, o_mem_cycles);
    if (el >= 0) chk("result latency", el, o_result_lat);
    if (emis >= 0) chk("mispredict", emis, mis);
    chk("exception cycle", eexc, exc_at);
    // Let an edge pass so the next offer does not reuse this time step
    @(negedge i_clock);
  endtask

  task automatic push(input logic [31:0] a);
    i_call = 1'b1;
    i_call_ret = a;
    @(negedge i_clock);
    i_call = 1'b0;
    @(negedge i_clock);
  endtask

  task automatic ret(input logic [31:0] tgt, input int ec, emis);
    int c;
    i_writes_pc = 1'b1;
    i_base_cycles = 5'h03;
    i_mem_cycles = 5'h03;
    i_load_target = tgt;
    go(ITR_OP_LDM, ec, 3, -1, emis, 0, c);
    if (emis == 0) chk("predicted target", tgt, o_pred_target);
    clr();
  endtask

  task automatic t_return();
    ret(32'h0000_0100, 11, 1);
    push(32'h0000_0100);
    ret(32'h0000_0100, 3, 0);
    push(32'h0000_0200);
    i_restores_status = 1'b1;
    ret(32'h0000_0bad, -1, -1);
    ret(32'h0000_0200, 3, 0);
    for (int i = 1; i <= 5; i++)
      push(32'(i * 16));
    for (int i = 5; i >= 2; i--)
      ret(32'(i * 16), 3, 0);
    ret(32'h0000_0010, 11, 1);
    push(32'h0000_0300);
    i_conditional = 1'b1;
    i_cond_mispredict = 1'b1;
    ret(32'h0000_0300, 10, 1);
    push(32'h0000_0400);
    i_conditional = 1'b1;
    ret(32'h0000_0444, 11, 1);
    push(32'h0000_0500);
    i_conditional = 1'b1;
    ret(32'h0000_0500, 3, 0);
  endtask

  // Multiple transfer, then a consumer offered back to back behind it
  task automatic pair(input itr_op_t op, input logic [4:0] m, lat,
                      input logic [3:0] src, last, input int exp_k);
    int k;
    clr();
    i_op = op;
    i_base_cycles = m;
    i_mem_cycles = m;
    i_last_lat = lat;
    i_load_last_reg = last;
    i_valid = 1'b1;
    @(negedge i_clock);
    i_op = ITR_OP_EXCL;
    i_consumer_valid = 1'b1;
    i_consumer_src = src;
    k = 1;
    #1;
    while (!o_ready && k < 30)
    begin
      @(negedge i_clock);
      #1;
      k++;
    end
    @(negedge i_clock);
    clr();
    i_valid = 1'b0;
    chk("consumer issue edge", exp_k, k);
    @(negedge i_clock);
  endtask

  task automatic t_interlock();
    clr();
    i_base_ready = 1'b0;
    i_op = ITR_OP_LDM;
    i_valid = 1'b1;
    repeat (3)
    begin
      @(negedge i_clock);
      chk("ready without base", 0, o_ready);
    end
    clr();
    i_valid = 1'b0;
    chk("stall after refusal", 0, o_stall);
    @(negedge i_clock);
    pair(ITR_OP_LDM, 5'h04, 5'h05, 4'h7, 4'h7, 5);
    pair(ITR_OP_LDM, 5'h04, 5'h05, 4'h3, 4'h7, 4);
    pair(ITR_OP_STM, 5'h04, 5'h00, 4'h7, 4'h7, 4);
    pair(ITR_OP_LDM, 5'h05, 5'h06, 4'h9, 4'h9, 6);
  endtask

  task automatic t_misc();
    int c;
    go(ITR_OP_RFE, 10, 1, -1, 0, 0, c);
    go(ITR_OP_SRS, 1, 1, -1, 0, 0, c);
    i_aligned = 1'b0;
    go(ITR_OP_RFE, 11, 2, -1, 0, 0, c);
    go(ITR_OP_SRS, 2, 2, -1, 0, 0, c);
    i_aligned = 1'b1;
    go(ITR_OP_EXCL, 1, 1, 2, 0, 0, c);
    go(ITR_OP_CLEAR_EXCLUSIVE_INSN, 1, -1, -1, 0, 0, c);
    go(ITR_OP_SWAP, 2, 2, 3, 0, 0, c);
    go(ITR_OP_COPROC, 6, -1, 6, 0, 0, c);
    go(ITR_OP_EXCEPT, 9, -1, -1, 0, 9, c);
    i_conditional = 1'b1;
    i_cond_pass = 1'b0;
    go(ITR_OP_COPROC, 4, -1, 4, 0, 0, c);
    go(ITR_OP_EXCEPT, 1, -1, -1, 0, 0, c);
    i_slow_undef = 1'b1;
    go(ITR_OP_EXCEPT, 2, -1, -1, 0, 0, c);
    clr();
  endtask

  task automatic t_barrier();
    drain = 1'b1;
    drain_len = 5'h03;
    @(negedge i_clock);
    drain = 1'b0;
    go(ITR_OP_BARRIER, -1, -1, -1, 0, 0, c3);
    drain = 1'b1;
    drain_len = 5'h09;
    @(negedge i_clock);
    drain = 1'b0;
    go(ITR_OP_BARRIER, -1, -1, -1, 0, 0, c9);
    chk("barrier stretch", 6, c9 - c3);
  endtask

  initial
  begin
    n_mismatch = 0;
    checks_done = 0;
    cyc = 0;
    i_rstn = 1'b0;
    i_valid = 1'b0;
    i_call = 1'b0;
    i_call_ret = 32'h0000_0000;
    drain = 1'b0;
    drain_len = 5'h00;
    clr();
    repeat (6) @(negedge i_clock);
    i_rstn = 1'b1;
    chk("stall after reset", 0, o_stall);
    t_return();
    t_interlock();
    t_misc();
    t_barrier();
    end_sim();
  end
endmodule
`default_nettype wire
